// ### hw/sfr_guard_map.svh
`ifndef SFR_GUARD_MAP_SVH
`define SFR_GUARD_MAP_SVH
// ****************************************************************
// Address map of guarded register space (word addresses, 8 bits)
// ****************************************************************
`define CPU_SFR_LO      8'h00
`define CPU_SFR_HI      8'h3f
`define HWC_SFR_LO      8'h40
`define HWC_SFR_HI      8'hbf
`define MMU_SFR_LO      8'hc0
`define MMU_SFR_HI      8'hff
`define MMU_TBL_PTR     8'hc0
`define MMU_HWC_PERM    8'hc1
// ****************************************************************
// Reset values and fixed firmware partition
// ****************************************************************
`define TBL_PTR_RST     16'h0000
`define HWC_PERM_RST    8'h00
`define SEG_EN_RST      8'h00
`define FW_PART_SEG     8'hc0
`endif

// ### hw/sfr_guard_pkg.sv
package sfr_guard_pkg;
    typedef enum logic [2:0] {
        MODE_SYS = 3'b001,
        MODE_USR = 3'b010,
        MODE_FW  = 3'b100
    } cpu_mode_t;

    typedef struct packed {
        logic        valid;
        logic        write;
        logic        is_sfr;
        logic [7:0]  addr;
        logic [15:0] wdata;
    } cpu_req_t;
endpackage

// ### hw/sfr_mem_guard.sv
`timescale 1ns/1ps
`include "sfr_guard_map.svh"
// Notes on behaviour
// - MMU registers reachable only in System Mode
// - System Mode reaches hardware component registers
// - User Mode sees only CPU registers by default
// - User Mode component access needs MMU grant
// - Segment table pointer written only in System Mode
// - Reset disables all segments, locks partition
// - Firmware partition is fixed, never alterable
// - Access attributes hardwired except component grants and segment enables
// - Privileged software updates segment attributes
// - Reset defines every register value and access
module sfr_mem_guard
    import sfr_guard_pkg::*;
#(
    parameter int SEG_N = 8
) (
    // Clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    // CPU side
    input  wire cpu_mode_t   i_mode,
    input  wire cpu_req_t    i_req,
    // Downstream register and memory space
    input  wire logic [15:0] i_rdata,
    output logic             o_fwd_valid,
    output logic             o_fwd_write,
    output logic [15:0]      o_rdata,
    output logic             o_violation,
    // Protection state seen by the memory path
    output logic [15:0]      o_tbl_ptr,
    output logic [SEG_N-1:0] o_seg_en,
    output logic [SEG_N-1:0] o_fw_part
);
    // ****************************************************************
    // Protection state
    // ****************************************************************
    logic [15:0]      tbl_ptr_ff,  nxt_tbl_ptr;
    logic [7:0]       usr_perm_ff, nxt_usr_perm;
    logic [7:0]       fw_perm_ff,  nxt_fw_perm;
    logic [SEG_N-1:0] seg_en_ff,   nxt_seg_en;
    logic             fwd_v_ff, nxt_fwd_v;
    logic             fwd_w_ff, nxt_fwd_w;
    logic [15:0]      rdata_ff, nxt_rdata;
    logic             viol_ff,  nxt_viol;
    logic             allow;
    logic             in_cpu, in_hwc, in_mmu;
    logic [2:0]       hwc_grp;
    logic             grant;

    // ****************************************************************
    // Address decode
    // ****************************************************************
    // Region decode; attribute table is hardwired here
    // Wired attributes leave no register that could loosen them
    always_comb begin
        in_cpu  = 1'b0;
        in_hwc  = 1'b0;
        in_mmu  = 1'b0;
        hwc_grp = i_req.addr[6:4] - 3'h4;
        if (i_req.addr >= `MMU_SFR_LO) begin
            in_mmu = 1'b1;
        end else if (i_req.addr >= `HWC_SFR_LO) begin
            in_hwc = 1'b1;
        end else begin
            in_cpu = 1'b1;
        end
    end

    // ****************************************************************
    // Access decision
    // ****************************************************************
    // Access decision uses the mode presented with the request itself
    // A mode change therefore costs no cycle and cannot race the check
    always_comb begin
        grant = 1'b0;
        allow = 1'b0;
        case (i_mode)
            MODE_USR: grant = usr_perm_ff[hwc_grp];
            MODE_FW:  grant = fw_perm_ff[hwc_grp];
            default:  grant = 1'b0;
        endcase
        if (!i_req.is_sfr) begin
            // Firmware partition only in Firmware Mode; segment must be on
            allow = seg_en_ff[i_req.addr[7:5]] &&
                    (o_fw_part[i_req.addr[7:5]] == (i_mode == MODE_FW));
        end else if (in_mmu) begin
            allow = (i_mode == MODE_SYS);
        end else if (in_hwc) begin
            allow = (i_mode == MODE_SYS) || grant;
        end else begin
            allow = in_cpu;
        end
        allow = allow & i_req.valid;
    end

    // ****************************************************************
    // Configuration and response
    // ****************************************************************
    // Next-state of configuration registers and response
    // Refused reads return zero rather than the downstream data
    always_comb begin
        nxt_tbl_ptr  = tbl_ptr_ff;
        nxt_usr_perm = usr_perm_ff;
        nxt_fw_perm  = fw_perm_ff;
        nxt_seg_en   = seg_en_ff;
        nxt_fwd_v    = allow;
        nxt_fwd_w    = allow & i_req.write;
        nxt_rdata    = 16'h0000;
        nxt_viol     = i_req.valid & ~allow;
        if (allow && !i_req.write) begin
            nxt_rdata = i_req.is_sfr && i_req.addr == `MMU_TBL_PTR ? tbl_ptr_ff : i_rdata;
        end
        if (allow && i_req.write && i_req.is_sfr && in_mmu) begin
            if (i_req.addr == `MMU_TBL_PTR) begin
                nxt_tbl_ptr = i_req.wdata;
            end else if (i_req.addr == `MMU_HWC_PERM) begin
                nxt_usr_perm = i_req.wdata[7:0];
                nxt_fw_perm  = i_req.wdata[15:8];
            end else begin
                nxt_seg_en = i_req.wdata[SEG_N-1:0];
            end
        end
    end

    // ****************************************************************
    // State registers
    // ****************************************************************
    // Registers; reset gives closed defaults
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            tbl_ptr_ff  <= `TBL_PTR_RST;
            usr_perm_ff <= `HWC_PERM_RST;
            fw_perm_ff  <= `HWC_PERM_RST;
            seg_en_ff   <= SEG_N'(`SEG_EN_RST);
            fwd_v_ff    <= 1'b0;
            fwd_w_ff    <= 1'b0;
            rdata_ff    <= 16'h0000;
            viol_ff     <= 1'b0;
        end else begin
            tbl_ptr_ff  <= nxt_tbl_ptr;
            usr_perm_ff <= nxt_usr_perm;
            fw_perm_ff  <= nxt_fw_perm;
            seg_en_ff   <= nxt_seg_en;
            fwd_v_ff    <= nxt_fwd_v;
            fwd_w_ff    <= nxt_fwd_w;
            rdata_ff    <= nxt_rdata;
            viol_ff     <= nxt_viol;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    // Outputs; partition is a constant so no write can reach it
    // Limitation: moving the partition needs a new build, by intent
    assign o_fwd_valid = fwd_v_ff;
    assign o_fwd_write = fwd_w_ff;
    assign o_rdata     = rdata_ff;
    assign o_violation = viol_ff;
    assign o_tbl_ptr   = tbl_ptr_ff;
    assign o_seg_en    = seg_en_ff;
    assign o_fw_part   = SEG_N'(`FW_PART_SEG);

    // ****************************************************************
    // Checks
    // ****************************************************************
    a_mmu_sys_only: assert property (@(posedge i_clk) disable iff (i_rst)
        i_req.valid && i_req.is_sfr && i_req.addr >= `MMU_SFR_LO && i_mode != MODE_SYS
        |=> o_violation && !o_fwd_valid) else $error("mmu access outside system");
    a_sys_hwc_ok: assert property (@(posedge i_clk) disable iff (i_rst)
        i_req.valid && i_req.is_sfr && in_hwc && i_mode == MODE_SYS
        |=> o_fwd_valid) else $error("system hwc access refused");
    a_usr_cpu_ok: assert property (@(posedge i_clk) disable iff (i_rst)
        i_req.valid && i_req.is_sfr && in_cpu && i_mode == MODE_USR
        |=> !o_violation) else $error("user cpu access refused");
    a_usr_no_grant: assert property (@(posedge i_clk) disable iff (i_rst)
        i_req.valid && i_req.is_sfr && in_hwc && i_mode == MODE_USR && !usr_perm_ff[hwc_grp]
        |=> o_violation) else $error("user hwc without grant");
    a_ptr_stable: assert property (@(posedge i_clk) disable iff (i_rst)
        i_mode != MODE_SYS |=> $stable(o_tbl_ptr)) else $error("pointer changed");
    a_seg_reset: assert property (@(posedge i_clk)
        $past(i_rst) && !i_rst |-> o_seg_en == '0) else $error("segments on after reset");
    a_part_fixed: assert property (@(posedge i_clk) disable iff (i_rst)
        ##1 $stable(o_fw_part)) else $error("partition changed");
    a_refuse_quiet: assert property (@(posedge i_clk) disable iff (i_rst)
        o_violation |-> !o_fwd_write && o_rdata == 16'h0000) else $error("refused leaked");
    a_seg_update: assert property (@(posedge i_clk) disable iff (i_rst)
        i_req.valid && i_req.write && i_req.is_sfr && i_mode == MODE_SYS && i_req.addr == 8'hc2
        |=> o_seg_en == $past(i_req.wdata[SEG_N-1:0])) else $error("segment update lost");

    // Grant paths: granted requests forwarded, pointer writes land, partition refused outside Firmware Mode
    a_mmu_sys_ok: assert property (@(posedge i_clk) disable iff (i_rst)
        i_req.valid && i_req.is_sfr && in_mmu && i_mode == MODE_SYS
        |=> o_fwd_valid) else $error("system mmu access refused");
    a_usr_grant: assert property (@(posedge i_clk) disable iff (i_rst)
        i_req.valid && i_req.is_sfr && in_hwc && i_mode == MODE_USR && usr_perm_ff[hwc_grp]
        |=> o_fwd_valid) else $error("user hwc grant ignored");
    a_fw_grant: assert property (@(posedge i_clk) disable iff (i_rst)
        i_req.valid && i_req.is_sfr && in_hwc && i_mode == MODE_FW
        |=> o_fwd_valid == $past(fw_perm_ff[hwc_grp])) else $error("firmware hwc grant wrong");
    a_part_guard: assert property (@(posedge i_clk) disable iff (i_rst)
        i_req.valid && !i_req.is_sfr && o_fw_part[i_req.addr[7:5]] && i_mode != MODE_FW
        |=> o_violation) else $error("partition reached outside firmware");
    a_ptr_write: assert property (@(posedge i_clk) disable iff (i_rst)
        i_req.valid && i_req.write && i_req.is_sfr && i_req.addr == `MMU_TBL_PTR
        && i_mode == MODE_SYS
        |=> o_tbl_ptr == $past(i_req.wdata)) else $error("pointer write lost");

    // One registered reply per request, none when idle
    a_one_answer: assert property (@(posedge i_clk) disable iff (i_rst)
        i_req.valid |=> o_fwd_valid != o_violation) else $error("request reply not unique");
    a_idle_quiet: assert property (@(posedge i_clk) disable iff (i_rst)
        !i_req.valid |=> !o_fwd_valid && !o_violation) else $error("reply without request");

    // Defaults seen on the first edge after reset is released
    a_ptr_reset: assert property (@(posedge i_clk)
        $past(i_rst) && !i_rst |-> o_tbl_ptr == `TBL_PTR_RST && usr_perm_ff == `HWC_PERM_RST
        && fw_perm_ff == `HWC_PERM_RST) else $error("defaults missing after reset");
endmodule

// ### dv/cpu_space_model.sv
`timescale 1ns/1ps
// ****************************************************************
// Register and memory space behind the guard
// ****************************************************************
module cpu_space_model (
    // Address of the request in flight
    input  wire logic [7:0]  i_addr,
    // Read data, same cycle as the request
    output logic [15:0]      o_rdata
);
    // Pattern differs per address so a stale or misrouted read shows up
    assign o_rdata = {i_addr, ~i_addr};
endmodule

// ### dv/mode_based_sfr_memory_guard_tb.sv
`timescale 1ns/1ps
module mode_based_sfr_memory_guard_tb;
    import sfr_guard_pkg::*;
    typedef struct packed {
        cpu_mode_t   m;
        logic        ok;
        logic        w;
        logic        s;
        logic [7:0]  a;
        logic [15:0] d;
        logic [15:0] rd;
    } row_t;
    logic        i_clk = 1'h0;
    logic        i_rst = 1'h1;
    cpu_mode_t   i_mode = MODE_SYS;
    cpu_req_t    i_req = '0;
    logic [15:0] i_rdata;
    logic        o_fwd_valid;
    logic        o_fwd_write;
    logic        o_violation;
    logic [15:0] o_rdata;
    logic [15:0] o_tbl_ptr;
    logic [7:0]  o_seg_en;
    logic [7:0]  o_fw_part;
    int          n_fail = 0;
    int          cmp_count = 0;
    int          cyc = 0;
    // ****************************************************************
    // Ordinary cases: mode, allowed, write, sfr, addr, wdata, rdata
    // ****************************************************************
    row_t rows[18] = '{
        '{MODE_SYS, 1, 1, 1, 8'hc0, 16'h1234, 16'h0},
        '{MODE_USR, 0, 1, 1, 8'hc0, 16'h5678, 16'h0},
        '{MODE_SYS, 1, 0, 1, 8'hc0, 16'h0, 16'h1234},
        '{MODE_FW,  0, 0, 1, 8'hc0, 16'h0, 16'h0},
        '{MODE_USR, 1, 0, 1, 8'h10, 16'h0, 16'h10ef},
        '{MODE_USR, 0, 0, 1, 8'h40, 16'h0, 16'h0},
        '{MODE_SYS, 1, 0, 1, 8'h40, 16'h0, 16'h40bf},
        '{MODE_SYS, 1, 1, 1, 8'hc1, 16'h0201, 16'h0},
        '{MODE_USR, 1, 0, 1, 8'h40, 16'h0, 16'h40bf},
        '{MODE_USR, 0, 0, 1, 8'h50, 16'h0, 16'h0},
        '{MODE_FW,  1, 0, 1, 8'h50, 16'h0, 16'h50af},
        '{MODE_FW,  0, 0, 1, 8'h40, 16'h0, 16'h0},
        '{MODE_SYS, 0, 0, 0, 8'h00, 16'h0, 16'h0},
        '{MODE_SYS, 1, 1, 1, 8'hc2, 16'h00c1, 16'h0},
        '{MODE_USR, 1, 0, 0, 8'h00, 16'h0, 16'h00ff},
        '{MODE_USR, 0, 0, 0, 8'hc0, 16'h0, 16'h0},
        '{MODE_FW,  1, 0, 0, 8'hc0, 16'h0, 16'hc03f},
        '{MODE_FW,  0, 0, 0, 8'h00, 16'h0, 16'h0}
    };
    sfr_mem_guard i_sfr_mem_guard (.i_clk(i_clk), .i_rst(i_rst), .i_mode(i_mode),
        .i_req(i_req), .i_rdata(i_rdata), .o_fwd_valid(o_fwd_valid),
        .o_fwd_write(o_fwd_write), .o_rdata(o_rdata), .o_violation(o_violation),
        .o_tbl_ptr(o_tbl_ptr), .o_seg_en(o_seg_en), .o_fw_part(o_fw_part));
    cpu_space_model i_cpu_space_model (.i_addr(i_req.addr), .o_rdata(i_rdata));
    // Clock, and a ceiling of 2000 cycles, well above the roughly 55 cycles the tests take
    initial begin
        forever #10 i_clk = ~i_clk;
    end
    always @(posedge i_clk) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            n_fail++;
            stop_test();
        end
    end
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        cmp_count++;
        if (g !== e) begin
            n_fail++;
            $display("Error t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    // One request, held one edge, answer checked once it has landed
    task automatic acc(input row_t x);
        @(posedge i_clk);
        i_mode <= x.m;
        i_req <= '{1'h1, x.w, x.s, x.a, x.d};
        @(posedge i_clk);
        i_req.valid <= 1'h0;
        #1;
        chk(16'({o_fwd_valid, o_violation, o_fwd_write}), 16'({x.ok, !x.ok, x.ok & x.w}));
        chk(o_rdata, x.rd);
    endtask
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge i_clk);
        i_rst <= 1'h0;
        #1;
        chk(o_tbl_ptr, 16'h0);
        chk({o_seg_en, o_fw_part}, 16'h00c0);
        $display("reset test done");
        foreach (rows[k]) acc(rows[k]);
        chk(o_tbl_ptr, 16'h1234);
        chk({o_seg_en, o_fw_part}, 16'hc1c0);
        $display("row tests done");
        // Back to back: mode flips between two requests
        @(posedge i_clk);
        i_mode <= MODE_SYS;
        i_req <= '{1'h1, 1'h0, 1'h1, 8'h60, 16'h0};
        @(posedge i_clk);
        i_mode <= MODE_USR;
        #1;
        chk(16'(o_fwd_valid), 16'h1);
        @(posedge i_clk);
        i_req.valid <= 1'h0;
        #1;
        chk(16'({o_fwd_valid, o_violation}), 16'h1);
        $display("mode change test done");
        // Second reset in mid-run drops the learnt attributes
        @(posedge i_clk);
        i_rst <= 1'h1;
        @(posedge i_clk);
        i_rst <= 1'h0;
        #1;
        chk(o_tbl_ptr, 16'h0);
        chk({o_seg_en, o_fw_part}, 16'h00c0);
        acc('{MODE_USR, 0, 0, 0, 8'h00, 16'h0, 16'h0});
        acc('{MODE_USR, 0, 0, 1, 8'h40, 16'h0, 16'h0});
        $display("second reset test done");
        stop_test();
    end
endmodule
